// file: src/pcc_pkg.sv
/*
 * Constants, field layout and types for the power and clock control
 * register block. Assumes a 10 MHz system clock and a 16-bit serial frame.
 */
package pcc_pkg;

    // register map
    localparam logic [6:0] PCC_REG_ADDR      = 7'h15;
    localparam logic [7:0] PCC_REG_RESET     = 8'h00;
    localparam logic [7:0] PCC_SHUTDOWN_WORD = 8'h08;

    // field positions
    localparam int PCC_SRC_HI   = 7;
    localparam int PCC_SRC_LO   = 6;
    localparam int PCC_DIV_HI   = 5;
    localparam int PCC_DIV_LO   = 4;
    localparam int PCC_SHUT_BIT = 3;
    localparam int PCC_RAW_BIT  = 2;
    localparam int PCC_PWR_HI   = 1;
    localparam int PCC_PWR_LO   = 0;

    // serial frame: read flag, 7-bit address, 8-bit data
    localparam int         PCC_RW_BIT     = 15;
    localparam int         PCC_ADDR_HI    = 14;
    localparam int         PCC_ADDR_LO    = 8;
    localparam logic [3:0] PCC_ADDR_LAST  = 4'h7;
    localparam logic [3:0] PCC_FRAME_LAST = 4'hF;
    localparam logic [15:0] PCC_RESUME_WORD = 16'hFFFF;

    typedef enum logic [1:0] {
        PCC_SRC_CMOS = 2'h0,
        PCC_SRC_XTAL = 2'h1,
        PCC_SRC_LVDS = 2'h2,
        PCC_SRC_RC   = 2'h3
    } pcc_clk_src_t;

    typedef enum logic [1:0] {
        PCC_DIV_16 = 2'h0,
        PCC_DIV_8  = 2'h1,
        PCC_DIV_4  = 2'h2,
        PCC_DIV_2  = 2'h3
    } pcc_div_t;

    typedef enum logic [1:0] {
        PCC_PWR_LOW  = 2'h0,
        PCC_PWR_RSVD = 2'h1,
        PCC_PWR_MED  = 2'h2,
        PCC_PWR_FAST = 2'h3
    } pcc_pwr_t;

    // half period of the modulator clock in master clock cycles
    function automatic logic [3:0] pcc_div_half(input pcc_div_t sel);
        case (sel)
            PCC_DIV_16: pcc_div_half = 4'h8;
            PCC_DIV_8:  pcc_div_half = 4'h4;
            PCC_DIV_4:  pcc_div_half = 4'h2;
            default:    pcc_div_half = 4'h1;
        endcase
    endfunction : pcc_div_half

    // effective core level; undefined code runs as low power
    function automatic pcc_pwr_t pcc_pwr_eff(input logic raw, input logic [1:0] field);
        if (raw || field == PCC_PWR_RSVD)
            pcc_pwr_eff = PCC_PWR_LOW;
        else
            pcc_pwr_eff = pcc_pwr_t'(field);
    endfunction : pcc_pwr_eff

endpackage : pcc_pkg

// file: src/pcc_div_if.sv
/*
 * Link between the register block and its modulator clock divider.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface pcc_div_if;
    import pcc_pkg::*;
    pcc_div_t div_sel;
    logic     run;
    logic     mod_clk;
    logic     mod_tick;

    modport ctrl (output div_sel, output run, input mod_clk, input mod_tick);
    modport div  (input div_sel, input run, output mod_clk, output mod_tick);
endinterface : pcc_div_if
`default_nettype wire

// file: src/pcc_clk_div.sv
/*
 * Modulator clock divider: master clock divided by 16, 8, 4 or 2.
 * Assumes run is held low while the device is shut down.
 */
`timescale 1ns/1ps
`default_nettype none
module pcc_clk_div (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // control side
    pcc_div_if.div    dv
);
    import pcc_pkg::*;

    typedef struct packed {
        logic [3:0] cnt;
        logic       clk_out;
        logic       tick;
    } pcc_div_st_t;

    localparam pcc_div_st_t DIV_RESET = '{cnt: 4'h0, clk_out: 1'b0, tick: 1'b0};

    pcc_div_st_t st_reg;
    pcc_div_st_t st_next;

    always_comb begin
        st_next      = st_reg;
        st_next.tick = 1'b0;
        if (!dv.run) begin
            st_next = DIV_RESET;
        end else if (st_reg.cnt >= pcc_div_half(dv.div_sel) - 4'h1) begin
            // >= so a smaller ratio chosen mid-count wraps at once
            st_next.cnt     = 4'h0;
            st_next.clk_out = ~st_reg.clk_out;
            st_next.tick    = ~st_reg.clk_out;
        end else begin
            st_next.cnt = st_reg.cnt + 4'h1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            st_reg <= DIV_RESET;
        else
            st_reg <= st_next;
    end

    assign dv.mod_clk  = st_reg.clk_out;
    assign dv.mod_tick = st_reg.tick;

    AST_DIV_HALT: assert property (@(posedge clk) disable iff (reset)
        !dv.run |=> !dv.mod_clk && !dv.mod_tick)
        else $error("divider runs while halted");

    AST_DIV_HALF: assert property (@(posedge clk) disable iff (reset)
        (dv.run && $past(dv.run) && $stable(dv.div_sel)) |-> st_reg.cnt < pcc_div_half(dv.div_sel))
        else $error("divider count beyond half period");

    AST_DIV_16: assert property (@(posedge clk) disable iff (reset)
        ($rose(dv.mod_clk) && dv.div_sel == PCC_DIV_16 && dv.run) ##1
        (dv.run && dv.div_sel == PCC_DIV_16) [*8] |-> !dv.mod_clk)
        else $error("divide by 16 high phase not eight cycles");

    AST_DIV_TICK: assert property (@(posedge clk) disable iff (reset)
        dv.mod_tick |-> $rose(dv.mod_clk))
        else $error("tick not on modulator clock rise");

endmodule : pcc_clk_div
`default_nettype wire

// file: src/pcc_power_clock_ctrl.sv
/*
 * Power and clock control register with its serial register port,
 * shutdown and resume handling, and the modulator clock divider.
 * Assumes serial pins are asynchronous to clk and much slower than it.
 */
`timescale 1ns/1ps
`default_nettype none
module pcc_power_clock_ctrl (
    // clock and reset pin
    input  wire logic            clk,
    input  wire logic            reset,
    // serial register port
    input  wire logic            cs_n,
    input  wire logic            sclk,
    input  wire logic            sdi,
    output logic                 sdo_out,
    output logic                 sdo_oe,
    // configuration outputs
    output pcc_pkg::pcc_clk_src_t clock_source_sel,
    output pcc_pkg::pcc_pwr_t    core_power_level,
    output logic                 raw_bitstream_enable,
    output logic                 powered_down,
    // modulator clock
    output logic                 modulator_clock_rate,
    output logic                 modulator_tick
);
    import pcc_pkg::*;

    typedef struct packed {
        logic       cs_meta;
        logic       cs_sync;
        logic       sclk_meta;
        logic       sclk_sync;
        logic       sclk_prev;
        logic       sdi_meta;
        logic       sdi_sync;
        logic [3:0] bit_cnt;
        logic [14:0] rx;
        logic [7:0] tx;
        logic [7:0] ctrl;
        pcc_pwr_t   pwr_out;
    } pcc_main_st_t;

    localparam pcc_main_st_t ST_RESET = '{
        cs_meta: 1'b1, cs_sync: 1'b1, sclk_meta: 1'b0, sclk_sync: 1'b0,
        sclk_prev: 1'b0, sdi_meta: 1'b0, sdi_sync: 1'b0, bit_cnt: 4'h0,
        rx: 15'h0000, tx: 8'h00, ctrl: PCC_REG_RESET, pwr_out: PCC_PWR_LOW};

    pcc_main_st_t st_reg;
    pcc_main_st_t st_next;

    // frame decode, all from synchronised copies
    logic        sclk_rise;
    logic        frame_done;
    logic [15:0] word;
    logic [7:0]  head;
    logic        shut;
    logic        wr_cmd;
    logic        wr_ok;
    logic        resume_hit;
    logic [7:0]  wr_val;

    pcc_div_if div_link ();

    always_comb begin
        shut       = st_reg.ctrl[PCC_SHUT_BIT];
        sclk_rise  = st_reg.sclk_sync && !st_reg.sclk_prev && !st_reg.cs_sync;
        word       = {st_reg.rx, st_reg.sdi_sync};
        head       = {st_reg.rx[6:0], st_reg.sdi_sync};
        frame_done = sclk_rise && st_reg.bit_cnt == PCC_FRAME_LAST;
        // serial port is dead in shutdown except for the resume pattern
        wr_cmd     = frame_done && !shut && !word[PCC_RW_BIT] &&
                     word[PCC_ADDR_HI:PCC_ADDR_LO] == PCC_REG_ADDR;
        // bit 3 only legal as the lone bit
        wr_ok      = wr_cmd && (!word[PCC_SHUT_BIT] || word[7:0] == PCC_SHUTDOWN_WORD);
        resume_hit = frame_done && shut && word == PCC_RESUME_WORD;
        wr_val     = word[7:0];
        if (wr_val[PCC_RAW_BIT])
            wr_val[PCC_PWR_HI:PCC_PWR_LO] = st_reg.ctrl[PCC_PWR_HI:PCC_PWR_LO];
    end

    always_comb begin
        st_next           = st_reg;
        st_next.cs_meta   = cs_n;
        st_next.cs_sync   = st_reg.cs_meta;
        st_next.sclk_meta = sclk;
        st_next.sclk_sync = st_reg.sclk_meta;
        st_next.sclk_prev = st_reg.sclk_sync;
        st_next.sdi_meta  = sdi;
        st_next.sdi_sync  = st_reg.sdi_meta;

        if (st_reg.cs_sync) begin
            st_next.bit_cnt = 4'h0;
            st_next.tx      = 8'h00;
        end else if (sclk_rise) begin
            st_next.rx      = word[14:0];
            st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
            if (st_reg.bit_cnt == PCC_ADDR_LAST) begin
                // read data must be ready before the host samples bit 7
                if (!shut && head[7] && head[6:0] == PCC_REG_ADDR)
                    st_next.tx = st_reg.ctrl;
                else
                    st_next.tx = 8'h00;
            end else begin
                st_next.tx = {st_reg.tx[6:0], 1'b0};
            end
        end

        if (resume_hit)
            st_next.ctrl[PCC_SHUT_BIT] = 1'b0;
        else if (wr_ok)
            st_next.ctrl = wr_val;

        st_next.pwr_out = pcc_pwr_eff(st_next.ctrl[PCC_RAW_BIT],
                                      st_next.ctrl[PCC_PWR_HI:PCC_PWR_LO]);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            st_reg <= ST_RESET;
        else
            st_reg <= st_next;
    end

    assign div_link.div_sel = pcc_div_t'(st_reg.ctrl[PCC_DIV_HI:PCC_DIV_LO]);
    assign div_link.run     = !shut;

    pcc_clk_div i_pcc_clk_div (
        .clk   (clk),
        .reset (reset),
        .dv    (div_link.div)
    );

    assign clock_source_sel     = pcc_clk_src_t'(st_reg.ctrl[PCC_SRC_HI:PCC_SRC_LO]);
    assign raw_bitstream_enable = st_reg.ctrl[PCC_RAW_BIT];
    assign core_power_level     = st_reg.pwr_out;
    assign powered_down         = shut;
    assign sdo_out              = st_reg.tx[7];
    // released in shutdown so a silent bus shows as no answer
    assign sdo_oe               = !st_reg.cs_sync && !shut;
    assign modulator_clock_rate = div_link.mod_clk;
    assign modulator_tick       = div_link.mod_tick;

    AST_SRC_FOLLOWS: assert property (@(posedge clk) disable iff (reset)
        wr_ok && !wr_val[PCC_SHUT_BIT] |=> clock_source_sel == $past(wr_val[PCC_SRC_HI:PCC_SRC_LO]))
        else $error("clock source not taken from write");

    AST_DIV_FOLLOWS: assert property (@(posedge clk) disable iff (reset)
        wr_ok |=> div_link.div_sel == $past(wr_val[PCC_DIV_HI:PCC_DIV_LO]))
        else $error("divider select not taken from write");

    AST_SHUT_ENTER: assert property (@(posedge clk) disable iff (reset)
        wr_cmd && word[7:0] == PCC_SHUTDOWN_WORD |=> powered_down ##1 !modulator_clock_rate)
        else $error("shutdown word did not power down");

    AST_SHUT_DISCARD: assert property (@(posedge clk) disable iff (reset)
        wr_cmd && word[PCC_SHUT_BIT] && word[7:0] != PCC_SHUTDOWN_WORD |=> $stable(st_reg.ctrl) && !powered_down)
        else $error("mixed shutdown write not discarded");

    AST_SHUT_SILENT: assert property (@(posedge clk) disable iff (reset)
        powered_down && !resume_hit |-> !sdo_oe ##1 $stable(st_reg.ctrl))
        else $error("serial port active in shutdown");

    AST_RESUME: assert property (@(posedge clk) disable iff (reset)
        resume_hit |=> !powered_down && sdo_oe == !st_reg.cs_sync)
        else $error("resume command did not wake device");

    AST_RAW_FOLLOWS: assert property (@(posedge clk) disable iff (reset)
        wr_ok |=> raw_bitstream_enable == $past(wr_val[PCC_RAW_BIT]))
        else $error("raw output enable not taken from write");

    AST_RAW_LOW: assert property (@(posedge clk) disable iff (reset)
        raw_bitstream_enable |-> core_power_level == PCC_PWR_LOW)
        else $error("raw output not forcing low power");

    AST_PWR_MAP: assert property (@(posedge clk) disable iff (reset)
        !raw_bitstream_enable && st_reg.ctrl[PCC_PWR_HI:PCC_PWR_LO] == PCC_PWR_FAST
        |-> core_power_level == PCC_PWR_FAST)
        else $error("power level not taken from field");

    AST_RESET_VAL: assert property (@(posedge clk) disable iff (reset)
        $past(reset) |-> st_reg.ctrl == PCC_REG_RESET && !powered_down)
        else $error("register not zero after reset");

    AST_READ_LOAD: assert property (@(posedge clk) disable iff (reset)
        sclk_rise && st_reg.bit_cnt == PCC_ADDR_LAST && !shut && head == {1'b1, PCC_REG_ADDR}
        |=> st_reg.tx == $past(st_reg.ctrl))
        else $error("read data not loaded from register");

    AST_READ_SHUT: assert property (@(posedge clk) disable iff (reset)
        sclk_rise && st_reg.bit_cnt == PCC_ADDR_LAST && shut |=> st_reg.tx == 8'h00)
        else $error("read data loaded in shutdown");

    AST_RAW_KEEPS: assert property (@(posedge clk) disable iff (reset)
        wr_ok && word[PCC_RAW_BIT] |=> st_reg.ctrl[PCC_PWR_HI:PCC_PWR_LO] == $past(st_reg.ctrl[PCC_PWR_HI:PCC_PWR_LO]))
        else $error("power field written while raw output on");

    AST_PWR_MED: assert property (@(posedge clk) disable iff (reset)
        !raw_bitstream_enable && st_reg.ctrl[PCC_PWR_HI:PCC_PWR_LO] == PCC_PWR_MED
        |-> core_power_level == PCC_PWR_MED)
        else $error("median level not taken from field");

    AST_PWR_LOW: assert property (@(posedge clk) disable iff (reset)
        st_reg.ctrl[PCC_PWR_HI:PCC_PWR_LO] != PCC_PWR_MED && st_reg.ctrl[PCC_PWR_HI:PCC_PWR_LO] != PCC_PWR_FAST
        |-> core_power_level == PCC_PWR_LOW)
        else $error("low level not taken from field");

    // resume touches only the shutdown bit
    AST_RESUME_KEEPS: assert property (@(posedge clk) disable iff (reset)
        resume_hit |=> st_reg.ctrl == ($past(st_reg.ctrl) & ~PCC_SHUTDOWN_WORD))
        else $error("resume changed other fields");

    AST_CTRL_HOLD: assert property (@(posedge clk) disable iff (reset)
        !wr_ok && !resume_hit |=> $stable(st_reg.ctrl))
        else $error("register changed without accepted write");

endmodule : pcc_power_clock_ctrl
`default_nettype wire

// file: testbench/pcc_host_model.sv
/*
 * Host controller model: drives 16-bit serial frames into the power and
 * clock control block. Assumes clk is the block's 10 MHz system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pcc_host_model (
    // clock
    input  wire logic clk,
    // serial pins
    output var logic  cs_n,
    output var logic  sclk,
    output var logic  sdi,
    input  wire logic sdo_out,
    input  wire logic sdo_oe
);
    // high if the block drove sdo at any sampling point of the last frame
    logic drove;

    initial begin
        cs_n  = 1'h1;
        sclk  = 1'h0;
        sdi   = 1'h0;
        drove = 1'h0;
    end

    // half period of 6 clk: block needs about 3 clk to have sdo ready
    task automatic xfer(input logic [15:0] word, output logic [7:0] rd);
        int i;
        rd    = 8'h00;
        drove = 1'h0;
        @(posedge clk);
        cs_n <= 1'h0;
        for (i = 15; i >= 0; i--) begin
            sclk <= 1'h0;
            sdi  <= word[i];
            repeat (6) @(posedge clk);
            sclk <= 1'h1;
            if (i < 8) begin
                rd[i] = sdo_oe ? sdo_out : 1'h0;
                drove = drove | (sdo_oe === 1'h1);
            end
            repeat (6) @(posedge clk);
        end
        cs_n <= 1'h1;
        // released line shows the inverse so a stale bit is never reused
        sdi  <= ~word[0];
        repeat (6) @(posedge clk);
    endtask : xfer
endmodule : pcc_host_model
`default_nettype wire

// file: testbench/pcc_power_clock_ctrl_tb.sv
/*
 * Self-checking bench for the power and clock control block.
 * Assumes the host model above supplies all serial traffic.
 */
`timescale 1ns/1ps
`default_nettype none
module pcc_power_clock_ctrl_tb;
    import pcc_pkg::*;
    logic         clk;
    logic         reset;
    logic         cs_n;
    logic         sclk;
    logic         sdi;
    logic         sdo_out;
    logic         sdo_oe;
    pcc_clk_src_t clock_source_sel;
    pcc_pwr_t     core_power_level;
    logic         raw_bitstream_enable;
    logic         powered_down;
    logic         modulator_clock_rate;
    logic         modulator_tick;
    int           mismatches = 0;
    int           checks = 0;
    logic [7:0]   rv;
    int           n;
    logic [1:0]   codes [3] = '{2'h2, 2'h3, 2'h1};
    logic [1:0]   levels [3] = '{2'h2, 2'h3, 2'h0};

    pcc_power_clock_ctrl i_pcc_power_clock_ctrl (
        .clk(clk), .reset(reset), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .clock_source_sel(clock_source_sel),
        .core_power_level(core_power_level), .raw_bitstream_enable(raw_bitstream_enable),
        .powered_down(powered_down), .modulator_clock_rate(modulator_clock_rate),
        .modulator_tick(modulator_tick)
    );

    pcc_host_model i_pcc_host_model (
        .clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe)
    );

    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [7:0] d);
        logic [7:0] dummy;
        i_pcc_host_model.xfer({1'h0, PCC_REG_ADDR, d}, dummy);
    endtask : wr

    task automatic rd(output logic [7:0] d);
        i_pcc_host_model.xfer({1'h1, PCC_REG_ADDR, 8'h00}, d);
    endtask : rd

    // clk cycles between two ticks; 100 means no tick was seen
    task automatic tick_period(output int p);
        int k;
        k = 0;
        while (modulator_tick !== 1'h1 && k < 100) begin
            @(posedge clk);
            k++;
        end
        @(posedge clk);
        p = 1;
        while (modulator_tick !== 1'h1 && p < 100) begin
            @(posedge clk);
            p++;
        end
    endtask : tick_period

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict

    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        give_verdict();
    end

    initial begin
        reset = 1'h1;
        repeat (3) @(posedge clk);
        reset <= 1'h0;
        repeat (4) @(posedge clk);
        rd(rv);
        check("reset value", 8'h00, rv);
        check("reset outputs", 8'h00, {2'h0, clock_source_sel, core_power_level, raw_bitstream_enable, powered_down});
        for (int s = 0; s < 4; s++) begin
            wr({s[1:0], 6'h00});
            check("clock_source_sel", {6'h00, s[1:0]}, {6'h00, clock_source_sel});
        end
        for (int d = 0; d < 4; d++) begin
            wr({2'h0, d[1:0], 4'h0});
            tick_period(n);
            check("modulator period", 8'(16 >> d), 8'(n));
            check("modulator_clock_rate at tick", 8'h01, {7'h00, modulator_clock_rate});
        end
        for (int c = 0; c < 3; c++) begin
            wr({6'h00, codes[c]});
            check("core_power_level", {6'h00, levels[c]}, {6'h00, core_power_level});
            rd(rv);
            check("stored level", {6'h00, codes[c]}, rv);
        end
        // raw on: written level bits ignored, stored median level kept
        wr(8'h02);
        wr(8'h05);
        check("raw_bitstream_enable", 8'h01, {7'h00, raw_bitstream_enable});
        check("level under raw", 8'h00, {6'h00, core_power_level});
        rd(rv);
        check("readback under raw", 8'h06, rv);
        wr(8'h03);
        check("raw off", 8'h03, {5'h00, raw_bitstream_enable, core_power_level});
        wr(8'h0C);
        rd(rv);
        check("mixed shutdown write", 8'h03, rv);
        check("still powered", 8'h00, {7'h00, powered_down});
        wr(PCC_SHUTDOWN_WORD);
        check("powered_down", 8'h01, {7'h00, powered_down});
        wr(8'h03);
        rd(rv);
        check("no sdo drive", 8'h00, {7'h00, i_pcc_host_model.drove});
        tick_period(n);
        check("modulator stopped", 8'h64, 8'(n));
        check("modulator_clock_rate low", 8'h00, {7'h00, modulator_clock_rate});
        i_pcc_host_model.xfer(PCC_RESUME_WORD, rv);
        check("resumed", 8'h00, {7'h00, powered_down});
        rd(rv);
        check("after resume", 8'h00, rv);
        wr(PCC_SHUTDOWN_WORD);
        check("down again", 8'h01, {7'h00, powered_down});
        reset <= 1'h1;
        repeat (2) @(posedge clk);
        reset <= 1'h0;
        repeat (4) @(posedge clk);
        check("reset exits", 8'h00, {7'h00, powered_down});
        rd(rv);
        check("value after reset", 8'h00, rv);
        give_verdict();
    end
endmodule : pcc_power_clock_ctrl_tb
`default_nettype wire
